// *** hw/dsj_regs.vh ***
// constants for the decrement, skip and paged jump slice
`ifndef DSJ_REGS_VH
`define DSJ_REGS_VH
// opcode upper-seven-bit prefixes (bit 8 is the d bit)
`define DSJ_OP_DEC 7'h03
`define DSJ_OP_DSZ 7'h0B
`define DSJ_OP_DSNZ 7'h13
// jump prefix, instruction bits 15..13
`define DSJ_OP_JMP 3'h6
`define DSJ_JMP_W 13
`define DSJ_JMP_MAX 13'h1FFF
// phase encoding
`define DSJ_PH_ONE 2'h0
`define DSJ_PH_TWO 2'h1
`define DSJ_PH_THREE 2'h2
`define DSJ_PH_FOUR 2'h3
// status flag bit positions in the flag vector
`define DSJ_FLG_C 0
`define DSJ_FLG_DC 1
`define DSJ_FLG_Z 2
`define DSJ_FLG_OV 3
`define DSJ_PC_RST 16'h0000
`define DSJ_LATCH_RST 8'h00
`endif

// *** hw/dsj_phase_gen.v ***
// four-phase sequencer producing the phase count and a one-cycle phase-four strobe
`timescale 1ns/1ps
module dsj_phase_gen (
  input wire clk_sys_in,
  input wire nrst_in,
  output wire [1:0] phase_out,
  output wire phase_four_out
);
`include "dsj_regs.vh"
  reg [1:0] phase_r;
  // free running, each phase is one core clock
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r <= `DSJ_PH_ONE;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign phase_out = phase_r;
  assign phase_four_out = (phase_r == `DSJ_PH_FOUR);
endmodule

// *** hw/dsj_decode_exec.v ***
// execute slice for decrement, decrement-skip and paged jump
//
// Contract
// - plain decrement subtracts one and updates zero, carry, dc, ov.
// - skip-on-null decrement is recognised by its upper prefix alone; the d bit is not decoded.
// - d clear sends the result to the accumulator, d set to the register.
// - skip-on-null with zero result turns the next cycle into a nop.
// - skip-on-nonnull decrement is recognised by its own prefix.
// - skip-on-nonnull with nonzero result turns the next cycle into a nop.
// - the jump is a three-bit prefix plus a 13-bit target.
// - the jump target stays inside the current 8K page.
// - the jump loads pc 12..0 and keeps pc 15..13.
// - after a jump the high latch holds pc 15..13 and target 12..8.
// - the jump takes two cycles, the second a nop, with no flag change.
`timescale 1ns/1ps
module dsj_decode_exec (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [15:0] instr_in,
  input wire [7:0] reg_rdata_in,
  input wire [3:0] flags_in,
  output reg [7:0] reg_addr_out,
  output wire reg_rd_out,
  output reg reg_wr_out,
  output reg [7:0] reg_wdata_out,
  output reg acc_wr_out,
  output reg [7:0] working_accumulator_out,
  output reg flags_wr_out,
  output reg [3:0] flags_out,
  output reg [15:0] pc_out,
  output reg [7:0] program_counter_high_latch_out,
  output wire flush_out,
  output wire [1:0] phase_out,
  output wire cycle_end_out,
  output wire unknown_op_out
);
`include "dsj_regs.vh"
  // ****************************************************
  // phase sequencing
  // ****************************************************
  // phase count and the phase-four strobe, shared by all steps
  wire [1:0] phase;
  wire ph4;
  dsj_phase_gen u_phase (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .phase_out(phase),
    .phase_four_out(ph4)
  );
  assign phase_out = phase;
  assign cycle_end_out = ph4;

  // ****************************************************
  // decode
  // ****************************************************
  // operation classes held in op_r for the rest of the cycle
  localparam OP_NONE = 3'h0;
  localparam OP_DEC = 3'h1;
  localparam OP_DSZ = 3'h2;
  localparam OP_DSNZ = 3'h3;
  localparam OP_JMP = 3'h4;

  // per-cycle state; nop_cycle_r marks a discarded cycle
  reg [15:0] ir_r;
  reg [2:0] op_r;
  reg nop_cycle_r;
  reg [7:0] operand_r;
  reg [7:0] result_r;
  reg skip_pend_r;

  // classify an instruction word
  function [2:0] dsj_classify;
    input [15:0] w;
    begin
      if (w[15:13] == `DSJ_OP_JMP)
        dsj_classify = OP_JMP;
      else if (w[15:9] == `DSJ_OP_DEC)
        dsj_classify = OP_DEC;
      else if (w[15:9] == `DSJ_OP_DSZ)
        dsj_classify = OP_DSZ;
      else if (w[15:9] == `DSJ_OP_DSNZ)
        dsj_classify = OP_DSNZ;
      else
        dsj_classify = OP_NONE;
    end
  endfunction

  // decrement with flag update; borrow clears carry
  function [11:0] dsj_decrement;
    input [7:0] v;
    reg [7:0] r;
    begin
      r = v - 8'h01;
      dsj_decrement = {r,
        (v == 8'h80), (r == 8'h00), (v[3:0] != 4'h0), (v != 8'h00)};
    end
  endfunction

  // decoded views of the cycle in flight
  wire [11:0] dec_all = dsj_decrement(operand_r);
  wire [2:0] op_now = dsj_classify(instr_in);
  wire dbit = ir_r[8];
  wire live = !nop_cycle_r;
  // only the decrement family reads the register file
  assign reg_rd_out = live && (phase == `DSJ_PH_TWO) &&
    (op_r == OP_DEC || op_r == OP_DSZ || op_r == OP_DSNZ);
  // limitation: other opcodes are only flagged, never executed
  assign unknown_op_out = live && (op_r == OP_NONE) &&
    (phase != `DSJ_PH_ONE);
  // flush is presented in phase four so fetch drops the next word
  assign flush_out = skip_pend_r && ph4;

  // ****************************************************
  // execute pipeline, one step per phase
  // ****************************************************
  // write pulses default low so each lasts exactly one clock
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ir_r <= 16'h0000;
      op_r <= OP_NONE;
      nop_cycle_r <= 1'b0;
      operand_r <= 8'h00;
      result_r <= 8'h00;
      skip_pend_r <= 1'b0;
      reg_addr_out <= 8'h00;
      reg_wr_out <= 1'b0;
      reg_wdata_out <= 8'h00;
      acc_wr_out <= 1'b0;
      working_accumulator_out <= 8'h00;
      flags_wr_out <= 1'b0;
      flags_out <= 4'h0;
    end else begin
      reg_wr_out <= 1'b0;
      acc_wr_out <= 1'b0;
      flags_wr_out <= 1'b0;
      case (phase)
        `DSJ_PH_ONE: begin
          // a discarded cycle does nothing in phases two to four
          nop_cycle_r <= skip_pend_r;
          skip_pend_r <= 1'b0;
          ir_r <= instr_in;
          op_r <= skip_pend_r ? OP_NONE : op_now;
          reg_addr_out <= instr_in[7:0];
        end
        `DSJ_PH_TWO: begin
          // operand taken from the register file
          if (live)
            operand_r <= reg_rdata_in;
        end
        `DSJ_PH_THREE: begin
          // skip decided here so flush can stand in phase four
          if (live) begin
            result_r <= dec_all[11:4];
            if (op_r == OP_DSZ && dec_all[11:4] == 8'h00)
              skip_pend_r <= 1'b1;
            if (op_r == OP_DSNZ && dec_all[11:4] != 8'h00)
              skip_pend_r <= 1'b1;
            if (op_r == OP_JMP)
              skip_pend_r <= 1'b1;
          end
        end
        `DSJ_PH_FOUR: begin
          // write-back to the destination chosen by the d bit
          if (live) begin
            case (op_r)
              OP_DEC, OP_DSZ, OP_DSNZ: begin
                if (dbit) begin
                  reg_wr_out <= 1'b1;
                  reg_wdata_out <= result_r;
                end else begin
                  acc_wr_out <= 1'b1;
                  working_accumulator_out <= result_r;
                end
                // only the plain decrement touches flags
                if (op_r == OP_DEC) begin
                  flags_wr_out <= 1'b1;
                  flags_out <= {dec_all[3], dec_all[2],
                    dec_all[1], dec_all[0]};
                end
              end
              OP_JMP: begin
                // pc and page latch move in their own process below
              end
              default: begin
                // opcodes outside this slice pass the flags through
                flags_out <= flags_in;
              end
            endcase
          end
        end
        default: begin
          // unreachable, the phase counter is only two bits wide
          op_r <= OP_NONE;
        end
      endcase
    end
  end

  // ****************************************************
  // program counter and page latch
  // ****************************************************
  // write-back of a live jump, in phase four only
  wire jmp_wb = live && (op_r == OP_JMP) && ph4;

  // a jump rewrites pc 12..0; every other cycle, discarded ones too,
  // counts one word, which is also how the 8K page ever changes
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_out <= `DSJ_PC_RST;
      program_counter_high_latch_out <= `DSJ_LATCH_RST;
    end else if (jmp_wb) begin
      // page bits kept, target confined to the current 8K page
      pc_out <= {pc_out[15:13], ir_r[12:0]};
      // latch takes the old page and target bits 12..8
      program_counter_high_latch_out <=
        {pc_out[15:13], ir_r[12:8]};
    end else if (ph4) begin
      pc_out <= pc_out + 16'h0001;
    end
  end
endmodule

// *** test/dsj_exec_chk.sv ***
// checker for the decrement, skip and paged jump execute slice
`timescale 1ns/1ps
`include "dsj_regs.vh"
module dsj_exec_chk (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [15:0] instr_in,
  input wire [7:0] reg_rdata_in,
  input wire reg_rd_out,
  input wire reg_wr_out,
  input wire acc_wr_out,
  input wire flags_wr_out,
  input wire [15:0] pc_out,
  input wire [7:0] program_counter_high_latch_out,
  input wire flush_out,
  input wire [1:0] phase_out,
  input wire cycle_end_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  reg skip_r;
  wire wr_any = reg_wr_out | acc_wr_out | flags_wr_out;
  wire take = (phase_out == 2'h0) & !skip_r;
  wire jmp = take & (instr_in[15:13] == `DSJ_OP_JMP);
  wire [2:0] pc_top = pc_out[15:13];
  wire [12:0] k_w = instr_in[12:0];
  // a flushed word must not look like a request
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= flush_out;
    end
  end
  a_end_phase: assert property (
    cycle_end_out == (phase_out == 2'h3))
    else $error("cycle end outside phase four");
  a_read_phase: assert property (
    reg_rd_out |-> phase_out == 2'h1)
    else $error("read strobe outside phase two");
  a_read_pulse: assert property (
    take && (instr_in[15:9] == `DSJ_OP_DEC ||
    instr_in[15:9] == `DSJ_OP_DSZ || instr_in[15:9] == `DSJ_OP_DSNZ)
    |=> reg_rd_out)
    else $error("no read strobe in phase two");
  a_write_slot: assert property (
    wr_any |-> $past(cycle_end_out))
    else $error("write pulse not after phase four");
  a_drop_quiet: assert property (
    flush_out |-> ##5 !wr_any)
    else $error("discarded word still wrote");
  a_drop_noread: assert property (
    flush_out |-> ##2 !reg_rd_out)
    else $error("discarded word still read");
  a_null_skip: assert property (
    take && instr_in[15:9] == `DSJ_OP_DSZ
    |-> ##3 flush_out == ($past(reg_rdata_in, 2) == 8'h01))
    else $error("skip on zero wrong");
  a_nonnull_skip: assert property (
    take && instr_in[15:9] == `DSJ_OP_DSNZ
    |-> ##3 flush_out == ($past(reg_rdata_in, 2) != 8'h01))
    else $error("skip on nonzero wrong");
  a_jump_flush: assert property (
    jmp |-> ##3 flush_out)
    else $error("jump did not discard next word");
  a_jump_pc: assert property (
    jmp |-> ##4 pc_out == {$past(pc_top, 4), $past(k_w, 4)})
    else $error("jump target wrong");
  a_jump_latch: assert property (
    jmp |-> ##4 program_counter_high_latch_out ==
    {$past(pc_top, 4), $past(k_w[12:8], 4)})
    else $error("high latch wrong after jump");
  a_jump_quiet: assert property (
    jmp |-> ##4 !wr_any)
    else $error("jump wrote data or flags");
  c_flush: cover property (flush_out);
  c_jump: cover property (jmp);
  c_acc: cover property (acc_wr_out);
endmodule
bind dsj_decode_exec dsj_exec_chk i_chk (.clk_sys_in, .nrst_in, .instr_in,
  .reg_rdata_in, .reg_rd_out, .reg_wr_out, .acc_wr_out, .flags_wr_out,
  .pc_out, .program_counter_high_latch_out, .flush_out, .phase_out,
  .cycle_end_out);

// *** test/dsj_decode_exec_tb.sv ***
// self-checking bench for the decrement, skip and paged jump slice
`timescale 1ns/1ps
module dsj_decode_exec_tb;
  typedef struct packed {
    logic [15:0] ins;
    logic [7:0] rd;
    logic [2:0] wr;
    logic [7:0] val;
    logic [3:0] flg;
    logic fl;
  } dsj_row_t;
  reg clk_sys_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [15:0] instr_in = 16'h0000;
  reg [7:0] reg_rdata_in = 8'h00;
  wire [7:0] reg_addr_out, reg_wdata_out, acc_out, latch_out;
  wire [3:0] flags_out;
  wire [15:0] pc_out;
  wire [1:0] phase_out;
  wire reg_rd_out, reg_wr_out, acc_wr_out, flags_wr_out, flush_out, unk;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer i;
  logic fl;
  logic un;
  dsj_row_t r;
  dsj_row_t rows [0:12];
  dsj_decode_exec i_dut (.clk_sys_in, .nrst_in, .instr_in, .reg_rdata_in,
    .flags_in(4'h5), .reg_addr_out, .reg_rd_out, .reg_wr_out, .reg_wdata_out,
    .acc_wr_out, .working_accumulator_out(acc_out), .flags_wr_out, .flags_out,
    .pc_out, .program_counter_high_latch_out(latch_out), .flush_out,
    .phase_out, .cycle_end_out(), .unknown_op_out(unk));
  // 25 MHz core clock
  always #20 clk_sys_in = ~clk_sys_in;
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // fixed four-clock cycle, so no handshake wait is needed
  task exec(input dsj_row_t x);
    instr_in = x.ins;
    reg_rdata_in = x.rd;
    repeat (3) @(negedge clk_sys_in);
    fl = flush_out;
    un = unk;
    @(negedge clk_sys_in);
  endtask
  initial begin
    // wr is {reg, acc, flags}; rows after a skip expect nothing at all
    rows[0] = '{16'h0712, 8'h01, 3'b101, 8'h00, 4'h7, 1'b0};
    rows[1] = '{16'h0634, 8'h80, 3'b011, 8'h7F, 4'h9, 1'b0};
    rows[2] = '{16'h0600, 8'h00, 3'b011, 8'hFF, 4'h0, 1'b0};
    rows[3] = '{16'h1701, 8'h01, 3'b100, 8'h00, 4'h0, 1'b1};
    rows[4] = '{16'hC123, 8'h05, 3'b000, 8'h00, 4'h0, 1'b0};
    rows[5] = '{16'h1602, 8'h03, 3'b010, 8'h02, 4'h0, 1'b0};
    rows[6] = '{16'h2603, 8'h03, 3'b010, 8'h02, 4'h0, 1'b1};
    rows[7] = '{16'h0778, 8'h05, 3'b000, 8'h00, 4'h0, 1'b0};
    rows[8] = '{16'h2704, 8'h01, 3'b100, 8'h00, 4'h0, 1'b0};
    rows[9] = '{16'hDABC, 8'h00, 3'b000, 8'h00, 4'h0, 1'b1};
    rows[10] = '{16'h0779, 8'h05, 3'b000, 8'h00, 4'h0, 1'b0};
    rows[11] = '{16'hDFFF, 8'h00, 3'b000, 8'h00, 4'h0, 1'b1};
    rows[12] = '{16'h0777, 8'h05, 3'b000, 8'h00, 4'h0, 1'b0};
    repeat (6) @(negedge clk_sys_in);
    chk({pc_out, latch_out}, 24'h0);
    nrst_in = 1'b1;
    for (i = 0; i < 13; i = i + 1) begin
      r = rows[i];
      chk(phase_out, 2'h0);
      exec(r);
      chk(fl, r.fl);
      chk(un, 1'b0);
      chk({reg_wr_out, acc_wr_out, flags_wr_out}, r.wr);
      if (r.wr[2])
        chk({reg_addr_out, reg_wdata_out}, {r.ins[7:0], r.val});
      if (r.wr[1]) chk(acc_out, r.val);
      if (r.wr[0]) chk(flags_out, r.flg);
      if (r.fl && r.ins[15:13] == 3'h6)
        chk({pc_out, latch_out},
          {3'h0, r.ins[12:0], 3'h0, r.ins[12:8]});
    end
    // opcode outside the slice: flagged, flags passed through, no write
    r = '{16'hB000, 8'h00, 3'b000, 8'h00, 4'h5, 1'b0};
    exec(r);
    chk(un, 1'b1);
    chk({reg_wr_out, acc_wr_out, flags_wr_out, flags_out}, 7'h05);
    // pc has counted past 8K, so a jump must keep page bits 001
    r = '{16'hC005, 8'h00, 3'b000, 8'h00, 4'h0, 1'b1};
    exec(r);
    chk(fl, 1'b1);
    chk({reg_wr_out, acc_wr_out, flags_wr_out}, 3'b000);
    chk({pc_out, latch_out}, 24'h200520);
    // reset in mid-instruction, then one cycle must run cleanly
    instr_in = 16'h0712;
    repeat (2) @(negedge clk_sys_in);
    nrst_in = 1'b0;
    @(negedge clk_sys_in);
    chk({pc_out, reg_wr_out, flush_out, phase_out}, 24'h0);
    nrst_in = 1'b1;
    exec(rows[1]);
    chk({acc_wr_out, acc_out}, 24'h17F);
    test_done;
  end
endmodule
